// *** dpms_pkg.sv ***
package dpms_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 18;
    localparam int SEM_N = 8;
    localparam int SEM_IDX_W = 3;
    localparam int CNT_W = 5;
    localparam int INIT_W = 4;
    localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR = 15'h7ffe;
    localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR = 15'h7fff;
    localparam logic SEM_TAKE = 1'b0;
    localparam logic SEM_FREE = 1'b1;
    localparam int CLK_PERIOD_NS = 4;
    // pin timing, least times, rounded up to whole cycles
    localparam int T_ARB_NS = 20;
    localparam int T_WP_NS = 20;
    localparam int T_ACC_NS = 20;
    localparam int SYNC_LAT = 2;
    localparam logic [CNT_W-1:0] ARB_CYC =
        CNT_W'((T_ARB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT);
    localparam logic [CNT_W-1:0] WP_CYC =
        CNT_W'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ACC_CYC =
        CNT_W'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT);

    typedef enum logic [2:0] {
        DPMS_OP_READ = 3'h0,
        DPMS_OP_WRITE = 3'h1,
        DPMS_OP_SEM_REQ = 3'h2,
        DPMS_OP_SEM_REL = 3'h3,
        DPMS_OP_SEM_READ = 3'h4,
        DPMS_OP_POST = 3'h5,
        DPMS_OP_ACK = 3'h6
    } dpms_op_t;

    typedef struct packed {
        dpms_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } dpms_cmd_t;

    typedef struct packed {
        logic ok;
        logic [DATA_W-1:0] data;
    } dpms_rsp_t;
endpackage

// *** dpms_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpms_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,         // system clock
    input wire logic nrst_in,        // async reset, active low
    input wire logic [W-1:0] d_in,   // asynchronous level
    output logic [W-1:0] q_out       // synchronised level
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_q <= '0;
        end else begin
            meta_q <= d_in;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q_out <= '0;
        end else begin
            q_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// *** dpms_port_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// Operation
// - right port reads 7FFF to clear flag
// - hold slave busy high, low blocks writes
// - width cascade uses one master's decision
// - depth cascade ANDs busy indications together
// - hold address and enable until busy settles
// - request by writing latch, then read back
// - failed verify means other port owns token
module dpms_port_ctrl
    import dpms_pkg::*;
#(
    parameter bit PORT_RIGHT = 1'b0,   // this controller drives the right port
    parameter int N_DEV = 1            // devices stacked in depth
) (
    input wire logic clk_in,                          // 250 MHz clock
    input wire logic nrst_in,                         // async reset, active low
    input wire logic cmd_valid_in,                    // command offered
    output logic cmd_ready_out,                       // command taken when both high
    input wire dpms_pkg::dpms_cmd_t cmd_in,           // command
    output logic rsp_valid_out,                       // one-cycle answer strobe
    output dpms_pkg::dpms_rsp_t rsp_out,              // answer data and status
    output logic [dpms_pkg::SEM_N-1:0] sem_owned_out, // tokens held by this port
    input wire logic lock_writes_in,                  // block writes on slave parts
    output logic mbox_irq_out,                        // own mailbox flag raised
    output logic init_done_out,                       // power-up init finished
    output logic [dpms_pkg::ADDR_W-1:0] addr_out,     // address pins
    output logic [dpms_pkg::DATA_W-1:0] data_out,     // data pins, driven value
    output logic data_oe_out,                         // data pins driven
    input wire logic [dpms_pkg::DATA_W-1:0] data_in,  // data pins, sensed value
    output logic chip_select_low_active_out,          // memory select, active low
    output logic chip_select_high_active_out,         // memory select, active high
    output logic flag_space_select_n_out,             // semaphore select, active low
    output logic write_strobe_n_out,                  // read/write pin, low writes
    output logic output_drive_n_out,                  // output enable, active low
    output logic write_block_n_out,                   // slave busy input drive
    input wire logic [N_DEV-1:0] busy_n_in,           // busy from each device
    input wire logic mailbox_irq_n_in                 // own interrupt pin, active low
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_SETUP = 6'b000010,
        ST_WRITE = 6'b000100,
        ST_RECOV = 6'b001000,
        ST_READ = 6'b010000,
        ST_DONE = 6'b100000
    } dpms_state_t;

    localparam logic [ADDR_W-1:0] OWN_MBOX = PORT_RIGHT ? MBOX_RIGHT_ADDR : MBOX_LEFT_ADDR;
    localparam logic [ADDR_W-1:0] PEER_MBOX = PORT_RIGHT ? MBOX_LEFT_ADDR : MBOX_RIGHT_ADDR;
    localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(SEM_N);

    dpms_state_t state_q;
    dpms_cmd_t cur_q;
    dpms_cmd_t next_cmd;
    logic readback_q;
    logic [CNT_W-1:0] cnt_q;
    logic [DATA_W-1:0] rdata_q;
    logic [INIT_W-1:0] init_idx_q;
    logic [DATA_W-1:0] data_s;
    logic [N_DEV-1:0] busy_s;
    logic irq_s;
    logic busy_n_all;
    logic cur_is_write;
    logic cur_is_sem;
    logic launch;

    dpms_sync #(.W(DATA_W + N_DEV + 1)) u_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        // busy and irq pins enter inverted so the cleared synchroniser reads as idle, not busy or irq
        .d_in({data_in, ~busy_n_in, ~mailbox_irq_n_in}),
        .q_out({data_s, busy_s, irq_s})
    );

    // one array-wide decision; any device flagging busy stalls a memory write, semaphore writes ignore it
    assign busy_n_all = ~|busy_s;

    assign cur_is_sem = (cur_q.op == DPMS_OP_SEM_REQ) || (cur_q.op == DPMS_OP_SEM_REL) ||
                        (cur_q.op == DPMS_OP_SEM_READ);
    assign cur_is_write = !readback_q && ((cur_q.op == DPMS_OP_WRITE) ||
                          (cur_q.op == DPMS_OP_SEM_REQ) || (cur_q.op == DPMS_OP_SEM_REL) ||
                          (cur_q.op == DPMS_OP_POST));
    assign launch = (state_q == ST_IDLE) && (!init_done_out || cmd_valid_in);

    // init first frees every semaphore from this side, then reads the own mailbox
    always_comb begin
        next_cmd = cmd_in;
        if (!init_done_out) begin
            if (init_idx_q < INIT_LAST) begin
                next_cmd.op = DPMS_OP_SEM_REL;
                next_cmd.addr = ADDR_W'(init_idx_q);
            end else begin
                next_cmd.op = DPMS_OP_ACK;
                next_cmd.addr = OWN_MBOX;
            end
            next_cmd.data = '0;
        end
        if (next_cmd.op == DPMS_OP_POST) begin
            next_cmd.addr = PEER_MBOX;
        end else if (next_cmd.op == DPMS_OP_ACK) begin
            next_cmd.addr = OWN_MBOX;
        end
        if (next_cmd.op == DPMS_OP_SEM_REQ) begin
            next_cmd.data = {DATA_W{SEM_TAKE}};
        end else if (next_cmd.op == DPMS_OP_SEM_REL) begin
            next_cmd.data = {DATA_W{SEM_FREE}};
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            init_idx_q <= '0;
            init_done_out <= 1'b0;
        end else if (!init_done_out && state_q == ST_DONE) begin
            if (init_idx_q == INIT_LAST) begin
                init_done_out <= 1'b1;
            end else begin
                init_idx_q <= init_idx_q + INIT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= ST_IDLE;
            cur_q <= '0;
            readback_q <= 1'b0;
            cnt_q <= '0;
            rdata_q <= '0;
            addr_out <= '0;
            data_out <= '0;
            data_oe_out <= 1'b0;
            chip_select_low_active_out <= 1'b1;
            chip_select_high_active_out <= 1'b0;
            flag_space_select_n_out <= 1'b1;
            write_strobe_n_out <= 1'b1;
            output_drive_n_out <= 1'b1;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (launch) begin
                        cur_q <= next_cmd;
                        readback_q <= 1'b0;
                        cnt_q <= '0;
                        data_out <= next_cmd.data;
                        if ((next_cmd.op == DPMS_OP_SEM_REQ) ||
                            (next_cmd.op == DPMS_OP_SEM_REL) ||
                            (next_cmd.op == DPMS_OP_SEM_READ)) begin
                            addr_out <= ADDR_W'(next_cmd.addr[SEM_IDX_W-1:0]);
                            flag_space_select_n_out <= 1'b0;
                        end else begin
                            addr_out <= next_cmd.addr;
                            chip_select_low_active_out <= 1'b0;
                            chip_select_high_active_out <= 1'b1;
                        end
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // address and selects stand still until busy has settled
                    if (cnt_q == ARB_CYC - CNT_W'(1)) begin
                        cnt_q <= '0;
                        if (cur_is_write) begin
                            if (cur_is_sem || busy_n_all) begin
                                write_strobe_n_out <= 1'b0;
                                data_oe_out <= 1'b1;
                                state_q <= ST_WRITE;
                            end
                        end else begin
                            output_drive_n_out <= 1'b0;
                            state_q <= ST_READ;
                        end
                    end else begin
                        cnt_q <= cnt_q + CNT_W'(1);
                    end
                end
                ST_WRITE: begin
                    if (cnt_q == WP_CYC - CNT_W'(1)) begin
                        cnt_q <= '0;
                        write_strobe_n_out <= 1'b1;
                        state_q <= ST_RECOV;
                    end else begin
                        cnt_q <= cnt_q + CNT_W'(1);
                    end
                end
                ST_RECOV: begin
                    // a dropped select releases the device's semaphore read latch
                    data_oe_out <= 1'b0;
                    chip_select_low_active_out <= 1'b1;
                    chip_select_high_active_out <= 1'b0;
                    flag_space_select_n_out <= 1'b1;
                    if (cur_q.op == DPMS_OP_SEM_REQ) begin
                        readback_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        state_q <= ST_DONE;
                    end
                end
                ST_READ: begin
                    if (cnt_q == ACC_CYC - CNT_W'(1)) begin
                        cnt_q <= '0;
                        rdata_q <= data_s;
                        output_drive_n_out <= 1'b1;
                        chip_select_low_active_out <= 1'b1;
                        chip_select_high_active_out <= 1'b0;
                        flag_space_select_n_out <= 1'b1;
                        state_q <= ST_DONE;
                    end else begin
                        cnt_q <= cnt_q + CNT_W'(1);
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
            // verify read of a request reuses the setup path with the flag select held low
            if (state_q == ST_RECOV && cur_q.op == DPMS_OP_SEM_REQ) begin
                state_q <= ST_SETUP;
                flag_space_select_n_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rsp_valid_out <= 1'b0;
            rsp_out <= '0;
            sem_owned_out <= '0;
        end else begin
            rsp_valid_out <= (state_q == ST_DONE) && init_done_out;
            if (state_q == ST_DONE) begin
                rsp_out.data <= rdata_q;
                rsp_out.ok <= 1'b1;
                if (cur_q.op == DPMS_OP_SEM_REQ) begin
                    // a one read back means the far port holds the token
                    rsp_out.ok <= (rdata_q[0] == SEM_TAKE);
                    sem_owned_out[cur_q.addr[SEM_IDX_W-1:0]] <= (rdata_q[0] == SEM_TAKE);
                end else if (cur_q.op == DPMS_OP_SEM_REL) begin
                    sem_owned_out[cur_q.addr[SEM_IDX_W-1:0]] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmd_ready_out <= 1'b0;
            mbox_irq_out <= 1'b0;
            write_block_n_out <= 1'b1;
        end else begin
            cmd_ready_out <= init_done_out && (state_q == ST_IDLE) && !cmd_valid_in;
            if (state_q == ST_DONE && init_done_out) begin
                cmd_ready_out <= 1'b1;
            end
            mbox_irq_out <= irq_s;
            write_block_n_out <= !lock_writes_in;
        end
    end
endmodule
`default_nettype wire

// *** dpms_port_ctrl_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpms_port_ctrl_chk #(
    parameter int N_DEV = 1
) (
    input wire logic clk_in, // clock
    input wire logic nrst_in, // reset
    input wire logic rsp_valid_out, // answer
    input wire logic [dpms_pkg::ADDR_W-1:0] addr_out, // address
    input wire logic data_oe_out, // data drive
    input wire logic chip_select_low_active_out, // select low
    input wire logic chip_select_high_active_out, // select high
    input wire logic flag_space_select_n_out, // flag select
    input wire logic write_strobe_n_out, // write strobe
    input wire logic output_drive_n_out, // output enable
    input wire logic write_block_n_out, // slave block
    input wire logic lock_writes_in, // lock request
    input wire logic [N_DEV-1:0] busy_n_in, // busy
    input wire logic mailbox_irq_n_in, // irq pin
    input wire logic mbox_irq_out // irq flag
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_mem_wr;
        $fell(write_strobe_n_out) && flag_space_select_n_out;
    endsequence
    sequence s_pulse;
        (!write_strobe_n_out && $stable(addr_out))[*5];
    endsequence
    a_pulse_held: assert property (s_mem_wr |-> s_pulse)
        else $error("write pulse short or address moved");
    a_setup_first: assert property (s_mem_wr |-> !$past(chip_select_low_active_out, 7))
        else $error("write pulse without arbitration setup");
    // five cycles cover the two-flop sync plus the launch edge
    a_busy_stalls: assert property ((!busy_n_in[0])[*5] |-> !$fell(write_strobe_n_out)
        || !flag_space_select_n_out)
        else $error("memory write launched while busy low");
    a_lock_follow: assert property (write_block_n_out == !$past(lock_writes_in))
        else $error("write block pin does not follow lock");
    a_done_idle: assert property (rsp_valid_out |-> chip_select_low_active_out
        && flag_space_select_n_out && write_strobe_n_out && output_drive_n_out)
        else $error("port still selected at answer");
    a_sel_pair: assert property (chip_select_low_active_out == !chip_select_high_active_out)
        else $error("chip selects disagree");
    a_flag_space: assert property (!flag_space_select_n_out |-> chip_select_low_active_out)
        else $error("memory selected with flag space");
    a_write_drive: assert property (!write_strobe_n_out |-> data_oe_out && output_drive_n_out)
        else $error("write strobe without data drive");
    a_irq_raise: assert property ($fell(mailbox_irq_n_in) |-> ##[1:4] mbox_irq_out)
        else $error("mailbox flag not raised");
    a_irq_clear: assert property ($rose(mailbox_irq_n_in) |-> ##[1:4] !mbox_irq_out)
        else $error("mailbox flag not cleared");
    a_rsp_pulse: assert property (rsp_valid_out |=> !rsp_valid_out)
        else $error("answer strobe longer than one cycle");
endmodule
bind dpms_port_ctrl dpms_port_ctrl_chk #(.N_DEV(N_DEV)) u_chk (.clk_in(clk_in),
    .nrst_in(nrst_in), .rsp_valid_out(rsp_valid_out), .addr_out(addr_out),
    .data_oe_out(data_oe_out), .chip_select_low_active_out(chip_select_low_active_out),
    .chip_select_high_active_out(chip_select_high_active_out),
    .flag_space_select_n_out(flag_space_select_n_out),
    .write_strobe_n_out(write_strobe_n_out), .output_drive_n_out(output_drive_n_out),
    .write_block_n_out(write_block_n_out), .lock_writes_in(lock_writes_in),
    .busy_n_in(busy_n_in), .mailbox_irq_n_in(mailbox_irq_n_in), .mbox_irq_out(mbox_irq_out));
`default_nettype wire

// *** dpms_dev_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpms_dev_model
    import dpms_pkg::*;
(
    input wire logic clk_in, // sampling clock
    input wire logic [dpms_pkg::ADDR_W-1:0] addr_in, // address
    input wire logic [dpms_pkg::DATA_W-1:0] wdata_in, // wire level
    input wire logic cs_n_in, // select low
    input wire logic cs_in, // select high
    input wire logic sem_n_in, // flag select
    input wire logic we_n_in, // write strobe
    input wire logic oe_n_in, // output enable
    input wire logic busy_force_n_in, // busy level
    input wire logic master_in, // role select, high for master
    input wire logic peer_hit_in, // peer holds our address first
    input wire logic peer_post_in, // peer writes our mailbox
    input wire logic [dpms_pkg::SEM_N-1:0] peer_req_in, // peer requests
    output logic [dpms_pkg::DATA_W-1:0] rdata_out, // read data
    output logic busy_n_out, // busy pin
    output logic irq_n_out, // own flag pin
    output logic peer_irq_out = 1'b0 // peer flag
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    // request latches start set: nothing clears them but the controller
    logic [SEM_N-1:0] own_l = '0, own_r = '0, req_l = '1;
    logic [DATA_W-1:0] last = '0;
    logic irq_l = 1'b1;
    wire sel = !cs_n_in && cs_in;
    wire rd = !oe_n_in && (sel || !sem_n_in);
    // master decides from select and address match only; slave passes the input
    assign busy_n_out = master_in ? !(sel && peer_hit_in) : busy_force_n_in;
    assign irq_n_out = !irq_l;
    // released bus shows the inverse so a stale value never passes
    assign rdata_out = !rd ? ~last : sem_n_in ? mem[addr_in] :
        {DATA_W{!own_l[addr_in[2:0]]}};
    // falling edge: pins never move at the controller's sampling edge
    always @(negedge clk_in) begin
        if (rd)
            last <= rdata_out;
    end
    always @(negedge clk_in) begin
        if (peer_post_in)
            irq_l = 1'b1;
        if (sel && !oe_n_in && addr_in == MBOX_LEFT_ADDR)
            irq_l = 1'b0;
        if (sel && !we_n_in && busy_n_out) begin
            mem[addr_in] = wdata_in;
            if (addr_in == MBOX_RIGHT_ADDR)
                peer_irq_out = 1'b1;
        end
        if (!sem_n_in && !we_n_in)
            req_l[addr_in[2:0]] = !wdata_in[0];
        for (int i = 0; i < SEM_N; i++) begin
            // peer evaluated first: a true tie goes to the peer
            own_r[i] = peer_req_in[i] && !own_l[i];
            own_l[i] = req_l[i] && !own_r[i];
        end
    end
endmodule
`default_nettype wire

// *** tb_dual_port_mailbox_semaphore.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_dual_port_mailbox_semaphore;
    import dpms_pkg::*;
    logic clk_in = 0, nrst_in = 0, valid = 0, lock = 0, busy_n = 1, post = 0;
    logic ready, rv, irq, idone, oe, cs_n, cs, sem_n, we_n, oe_n, wb_n, irq_n, busy_d, pirq;
    logic [SEM_N-1:0] preq = '0, owned;
    logic master = 0, phit = 0;
    dpms_cmd_t cmd = '0;
    dpms_rsp_t rsp;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout, din, rdev;
    int errors = 0, compares = 0;
    always #2 clk_in = ~clk_in;
    assign din = oe ? dout : rdev;
    dpms_port_ctrl #(.PORT_RIGHT(1'b0), .N_DEV(1)) dut (.clk_in(clk_in), .nrst_in(nrst_in),
        .cmd_valid_in(valid), .cmd_ready_out(ready), .cmd_in(cmd), .rsp_valid_out(rv),
        .rsp_out(rsp), .sem_owned_out(owned), .lock_writes_in(lock), .mbox_irq_out(irq),
        .init_done_out(idone), .addr_out(addr), .data_out(dout), .data_oe_out(oe),
        .data_in(din), .chip_select_low_active_out(cs_n), .chip_select_high_active_out(cs),
        .flag_space_select_n_out(sem_n), .write_strobe_n_out(we_n),
        .output_drive_n_out(oe_n), .write_block_n_out(wb_n), .busy_n_in(busy_d),
        .mailbox_irq_n_in(irq_n));
    dpms_dev_model dev (.clk_in(clk_in), .addr_in(addr), .wdata_in(din), .cs_n_in(cs_n),
        .cs_in(cs), .sem_n_in(sem_n), .we_n_in(we_n), .oe_n_in(oe_n), .busy_force_n_in(busy_n),
        .master_in(master), .peer_hit_in(phit),
        .peer_post_in(post), .peer_req_in(preq), .rdata_out(rdev), .busy_n_out(busy_d),
        .irq_n_out(irq_n), .peer_irq_out(pirq));
    task automatic end_of_test();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic issue(input dpms_op_t op, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d);
        cmd = {op, a, d};
        valid = 1'b1;
        for (int i = 0; i < 100 && ready !== 1'b1; i++) @(posedge clk_in) #1;
        @(posedge clk_in);
        #1 valid = 1'b0;
    endtask
    task automatic await(input int lim, output logic got);
        got = 1'b0;
        for (int i = 0; i < lim && !got; i++) @(posedge clk_in) #1 got = (rv === 1'b1);
    endtask
    task automatic run(input dpms_op_t op, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        logic got;
        issue(op, a, d);
        await(200, got);
        check(got, 1'b1);
        check(ready, 1'b1);
    endtask
    task automatic t_init();
        repeat (400) if (idone !== 1'b1) @(posedge clk_in);
        repeat (6) @(posedge clk_in);
        #1 check(idone, 1'b1);
        check(dev.req_l, '0);
        check(irq, 1'b0);
    endtask
    task automatic t_mem();
        run(DPMS_OP_WRITE, 15'h0000, 18'h3ffff);
        run(DPMS_OP_WRITE, 15'h7ffd, 18'h2a5a5);
        run(DPMS_OP_READ, 15'h0000, '0);
        check(rsp.data, 18'h3ffff);
        run(DPMS_OP_READ, 15'h7ffd, '0);
        check(rsp.data, 18'h2a5a5);
        run(DPMS_OP_POST, '0, 18'h1c3c3);
        check(pirq, 1'b1);
        run(DPMS_OP_READ, MBOX_RIGHT_ADDR, '0);
        check(rsp.data, 18'h1c3c3);
    endtask
    task automatic t_irq();
        dev.mem[MBOX_LEFT_ADDR] = 18'h00777;
        post = 1'b1;
        @(posedge clk_in);
        #1 post = 1'b0;
        repeat (6) @(posedge clk_in);
        #1 check(irq, 1'b1);
        run(DPMS_OP_ACK, '0, '0);
        check(rsp.data, 18'h00777);
        repeat (6) @(posedge clk_in);
        #1 check(irq, 1'b0);
    endtask
    task automatic t_sem();
        run(DPMS_OP_SEM_REQ, 15'h7ff3, '0);
        check(rsp.ok, 1'b1);
        check(owned[3], 1'b1);
        run(DPMS_OP_SEM_READ, 15'h0003, '0);
        check(rsp.data, 18'h00000);
        preq = 8'h28;
        run(DPMS_OP_SEM_REQ, 15'h0005, '0);
        check(rsp.ok, 1'b0);
        check(owned[5], 1'b0);
        run(DPMS_OP_SEM_REL, 15'h0003, '0);
        check(owned[3], 1'b0);
        check(dev.own_r[3], 1'b1);
        run(DPMS_OP_SEM_READ, 15'h0003, '0);
        check(rsp.data, 18'h3ffff);
        preq = '0;
    endtask
    task automatic t_busy();
        logic got;
        dev.mem[15'h0100] = '0;
        busy_n = 1'b0;
        lock = 1'b1;
        issue(DPMS_OP_WRITE, 15'h0100, 18'h15555);
        await(40, got);
        check(got, 1'b0);
        check(ready, 1'b0);
        check(dev.mem[15'h0100], 18'h00000);
        check(wb_n, 1'b0);
        busy_n = 1'b1;
        lock = 1'b0;
        await(200, got);
        check(got, 1'b1);
        check(dev.mem[15'h0100], 18'h15555);
        check(wb_n, 1'b1);
        master = 1'b1;
        phit = 1'b1;
        dev.mem[15'h0101] = '0;
        issue(DPMS_OP_WRITE, 15'h0101, 18'h0aaaa);
        await(40, got);
        check(got, 1'b0);
        check(dev.mem[15'h0101], 18'h00000);
        phit = 1'b0;
        await(200, got);
        check(got, 1'b1);
        check(dev.mem[15'h0101], 18'h0aaaa);
        master = 1'b0;
    endtask
    initial begin
        #100000;
        errors++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        t_init();
        t_mem();
        t_irq();
        t_sem();
        t_busy();
        end_of_test();
    end
endmodule
`default_nettype wire
